/* File: rtl/can_rx_opts_defs.svh */
// register offsets, field positions and reset values of the option block
`ifndef CAN_RX_OPTS_DEFS_SVH
`define CAN_RX_OPTS_DEFS_SVH

`define OFS_GLOBAL_CONFIG   12'h000
`define OFS_PAYLOAD_SIZE    12'h004
`define OFS_ERROR_FLAGS     12'h008
`define OFS_TIMESTAMP       12'h00C

`define CFG_DCE_BIT         0
`define CFG_DRE_BIT         1
`define CFG_MME_BIT         2
`define CFG_CLKSRC_BIT      3
`define CFG_OVFMODE_BIT     4
`define CFG_TSSRC_BIT       5
`define CFG_TSCH_LSB        8
`define CFG_TSDIV_LSB       12
`define CFG_RESET           32'h0000_0000
`define CFG_WMASK           32'h0000_F33F

`define PLS_RXBUF_LSB       0
`define PLS_RXFIFO_LSB      4
`define PLS_TXRX_LSB        8
`define PLS_RESET           32'h0000_0000
`define PLS_WMASK           32'h0000_0777

`define ERR_DLC_BIT         0
`define ERR_OVF_BIT         1

`define TS_RESET            16'h0000
`define DEST_RXBUF          2'h0
`define DEST_RXFIFO         2'h1
`define DEST_TXRXFIFO       2'h2

`endif

/* File: rtl/can_rx_opts_pkg.sv */
// types shared by the receive option block
package can_rx_opts_pkg;
    typedef logic [3:0]  dlc_t;
    typedef logic [2:0]  pls_t;
    typedef logic [1:0]  dest_t;
    typedef logic [15:0] stamp_t;
    typedef logic [6:0]  nbytes_t;
endpackage

/* File: rtl/can_rx_global_filter_options.sv */
// global receive options: dlc filter, mirror, overflow, timestamp, apb
// Summary of operation
// - dlc check on filters accepted frames
// - dlc check off skips length comparison
// - pass when frame dlc at least rule
// - shorter frame dropped, dlc error recorded
// - substitution only while dlc check on
// - substitution stores rule dlc, zero tail
// - no substitution stores own dlc, bytes
// - mirror feeds own frames to rules
// - loopback target bit selects frame origin
// - global bit selects can clock source
// - overflow mode 0 discards oversized frame
// - overflow mode 1 truncates oversized frame
// - 3-bit payload size per buffer kind
// - 16-bit wrapping timestamp counter
// - timestamp captured at start of frame
// - timestamp from pclk/2 or bit clock
// - timestamp tick passes through divider
// - bit clock source halts with channel
// - pclk/2 source ignores channel modes
// - oversized payload sets overflow flag
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_opts_defs.svh"

module can_rx_global_filter_options #(
    parameter int NUM_CH     = 4,
    parameter int DATA_BYTES = 64
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [NUM_CH-1:0]           chan_bit_tick,
    input  wire logic [NUM_CH-1:0]           chan_stopped,
    input  wire logic                        frm_sof,
    input  wire logic                        frm_valid,
    input  wire logic                        frm_is_own,
    input  wire can_rx_opts_pkg::dlc_t       frm_dlc,
    input  wire logic [8*DATA_BYTES-1:0]     frm_data,
    input  wire logic                        rule_loopback_target,
    input  wire can_rx_opts_pkg::dlc_t       rule_dlc,
    input  wire can_rx_opts_pkg::dest_t      frm_dest,
    output logic                             st_valid,
    output can_rx_opts_pkg::dlc_t            st_dlc,
    output logic      [8*DATA_BYTES-1:0]     st_data,
    output can_rx_opts_pkg::stamp_t          st_timestamp,
    output can_rx_opts_pkg::dest_t           st_dest,
    output logic                             can_clock_source_select
);
    import can_rx_opts_pkg::*;
    default clocking chk_clk @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    if (NUM_CH < 1 || NUM_CH > 4 || DATA_BYTES != 64)
    begin : g_bad_params
        $error("unsupported channel count or payload width");
    end

    function automatic nbytes_t dlc_bytes(input dlc_t d);
        case (d)
            4'h9:    dlc_bytes = 7'd12;
            4'hA:    dlc_bytes = 7'd16;
            4'hB:    dlc_bytes = 7'd20;
            4'hC:    dlc_bytes = 7'd24;
            4'hD:    dlc_bytes = 7'd32;
            4'hE:    dlc_bytes = 7'd48;
            4'hF:    dlc_bytes = 7'd64;
            default: dlc_bytes = {3'h0, d};
        endcase
    endfunction

    function automatic nbytes_t pls_bytes(input pls_t p);
        pls_bytes = dlc_bytes(4'h8 + {1'b0, p});
    endfunction

    logic [31:0]     cfg_ff;
    logic [31:0]     pls_ff;
    logic [1:0]      err_ff;
    stamp_t          ts_ff;
    logic            half_ff;
    logic [15:0]     div_ff;
    stamp_t          sof_ts_ff;

    // apb decode
    logic            setup;
    logic            wr_en;
    logic            mapped;
    logic [31:0]     rd_mux;

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite && mapped;
    assign pready = 1'b1;

    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == `OFS_GLOBAL_CONFIG)
            rd_mux = cfg_ff;
        else if (paddr == `OFS_PAYLOAD_SIZE)
            rd_mux = pls_ff;
        else if (paddr == `OFS_ERROR_FLAGS)
            rd_mux = {30'h0, err_ff};
        else if (paddr == `OFS_TIMESTAMP)
            rd_mux = {16'h0, ts_ff};
        else
            mapped = 1'b0;
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    // is kept by software; writes land whatever the channel mode
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cfg_ff <= `CFG_RESET;
        else if (wr_en && paddr == `OFS_GLOBAL_CONFIG)
            cfg_ff <= pwdata & `CFG_WMASK;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            pls_ff <= `PLS_RESET;
        else if (wr_en && paddr == `OFS_PAYLOAD_SIZE)
            pls_ff <= pwdata & `PLS_WMASK;
    end

    logic            dce;
    logic            dlc_substitute_enable;
    logic            mirror_enable;
    logic            ovf_mode;
    logic            ts_from_ch;
    logic [1:0]      ts_ch;
    logic [3:0]      ts_div;

    assign dce        = cfg_ff[`CFG_DCE_BIT];
    assign dlc_substitute_enable        = cfg_ff[`CFG_DRE_BIT];
    assign mirror_enable        = cfg_ff[`CFG_MME_BIT];
    assign ovf_mode   = cfg_ff[`CFG_OVFMODE_BIT];
    assign ts_from_ch = cfg_ff[`CFG_TSSRC_BIT];
    assign ts_ch      = cfg_ff[`CFG_TSCH_LSB +: 2];
    assign ts_div     = cfg_ff[`CFG_TSDIV_LSB +: 4];
    assign can_clock_source_select = cfg_ff[`CFG_CLKSRC_BIT];

    // frame qualification
    logic            rule_hit;
    logic            check_on;
    logic            dlc_reject;
    logic            subst;
    pls_t            dest_pls;
    nbytes_t         buf_bytes;
    nbytes_t         rx_bytes;
    nbytes_t         keep_bytes;
    logic            overflow;
    logic            do_store;
    logic            set_dlc_err;
    logic            set_ovf;

    always_comb
    begin
        rule_hit = frm_valid &&
            (rule_loopback_target ? (frm_is_own && mirror_enable) : !frm_is_own);
        check_on   = dce && (rule_dlc != 4'h0);
        dlc_reject = check_on && (frm_dlc < rule_dlc);
        subst      = check_on && dlc_substitute_enable;
        if (frm_dest == `DEST_RXBUF)
            dest_pls = pls_ff[`PLS_RXBUF_LSB +: 3];
        else if (frm_dest == `DEST_RXFIFO)
            dest_pls = pls_ff[`PLS_RXFIFO_LSB +: 3];
        else
            dest_pls = pls_ff[`PLS_TXRX_LSB +: 3];
        buf_bytes = pls_bytes(dest_pls);
        rx_bytes  = dlc_bytes(frm_dlc);
        overflow  = rx_bytes > buf_bytes;
        keep_bytes = subst ? dlc_bytes(rule_dlc) : rx_bytes;
        if (keep_bytes > buf_bytes)
            keep_bytes = buf_bytes;
        do_store    = rule_hit && !dlc_reject && (!overflow || ovf_mode);
        set_dlc_err = rule_hit && dlc_reject;
        set_ovf     = rule_hit && !dlc_reject && overflow;
    end

    // error flags: write one to clear, a new event beats the clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            err_ff <= 2'h0;
        else
        begin
            err_ff[`ERR_DLC_BIT] <= set_dlc_err || (err_ff[`ERR_DLC_BIT] &&
                !(wr_en && paddr == `OFS_ERROR_FLAGS &&
                  pwdata[`ERR_DLC_BIT]));
            err_ff[`ERR_OVF_BIT] <= set_ovf || (err_ff[`ERR_OVF_BIT] &&
                !(wr_en && paddr == `OFS_ERROR_FLAGS &&
                  pwdata[`ERR_OVF_BIT]));
        end
    end

    // store path
    logic [8*DATA_BYTES-1:0] masked;

    always_comb
    begin
        masked = frm_data;
        for (int i = 0; i < DATA_BYTES; i++)
        begin
            if (i >= int'(keep_bytes))
                masked[8*i +: 8] = 8'h00;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st_valid <= 1'b0;
        else
            st_valid <= do_store;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_dlc       <= 4'h0;
            st_data      <= '0;
            st_timestamp <= `TS_RESET;
            st_dest      <= `DEST_RXBUF;
        end
        else if (do_store)
        begin
            st_dlc       <= subst ? rule_dlc : frm_dlc;
            st_data      <= masked;
            st_timestamp <= sof_ts_ff;
            st_dest      <= frm_dest;
        end
    end

    // timestamp source, divider and counter
    logic            src_tick;
    logic            ch_run;
    logic [15:0]     div_mask;
    logic            ts_tick;

    assign ch_run   = !chan_stopped[ts_ch];
    assign src_tick = ts_from_ch ? (chan_bit_tick[ts_ch] && ch_run)
                                 : half_ff;
    assign div_mask = 16'hFFFF >> (5'h10 - {1'b0, ts_div});
    assign ts_tick  = src_tick && ((div_mask & ~div_ff) == 16'h0000
                                   || ts_div == 4'h0);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            half_ff <= 1'b0;
        else
            half_ff <= !half_ff;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            div_ff <= 16'h0000;
        else if (src_tick)
            div_ff <= ts_tick ? 16'h0000 : div_ff + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ts_ff <= `TS_RESET;
        else if (ts_tick)
            ts_ff <= ts_ff + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sof_ts_ff <= `TS_RESET;
        else if (frm_sof)
            sof_ts_ff <= ts_ff;
    end

    // checks
    sequence s_short_frame;
        frm_valid && dce && rule_dlc != 4'h0 && frm_dlc < rule_dlc;
    endsequence

    sequence s_own_unmirrored;
        frm_valid && frm_is_own && !mirror_enable;
    endsequence

    sequence s_sof_to_store;
        frm_sof ##1 (!frm_sof) [*3] ##1 (do_store && !frm_sof);
    endsequence

    AST_DLC_SHORT_DROP: assert property (s_short_frame and rule_hit
        |=> !st_valid && err_ff[`ERR_DLC_BIT])
        else $error("short frame stored or no dlc error");

    AST_NO_CHECK_PASS: assert property (frm_valid && !dce
        && !frm_is_own && !rule_loopback_target && !overflow
        |=> st_valid && st_dlc == $past(frm_dlc))
        else $error("unchecked frame not stored as received");

    AST_DLC_PASS: assert property (rule_hit && dce
        && frm_dlc >= rule_dlc && !overflow |=> st_valid)
        else $error("long enough frame not stored");

    AST_SUBST_DLC: assert property (do_store && dce && dlc_substitute_enable
        && rule_dlc != 4'h0 |=> st_dlc == $past(rule_dlc))
        else $error("substituted dlc wrong");

    AST_SUBST_OFF: assert property (do_store
        && (!dce || rule_dlc == 4'h0) |=> st_dlc == $past(frm_dlc))
        else $error("dlc substituted while check off");

    AST_OWN_DROP: assert property (s_own_unmirrored |=> !st_valid)
        else $error("own frame stored without mirror");

    AST_OVF_DROP: assert property (rule_hit && !dlc_reject
        && overflow && !ovf_mode |=> !st_valid && err_ff[`ERR_OVF_BIT])
        else $error("oversized frame stored in discard mode");

    AST_OVF_TRUNC: assert property (rule_hit && !dlc_reject
        && overflow && ovf_mode
        |=> st_valid && st_data[8*DATA_BYTES-1 -: 8] == 8'h00)
        else $error("oversized frame not truncated");

    AST_TS_HALT: assert property (ts_from_ch && chan_stopped[ts_ch]
        && $stable(cfg_ff) ##1 ts_from_ch && chan_stopped[ts_ch]
        |-> $stable(ts_ff))
        else $error("timestamp ran while channel stopped");

    AST_TS_HALF: assert property (!ts_from_ch && ts_div == 4'h0
        && $stable(cfg_ff) ##1 !ts_from_ch && ts_div == 4'h0
        ##1 !ts_from_ch && ts_div == 4'h0 |-> ts_ff != $past(ts_ff, 2))
        else $error("timestamp not advancing on pclk/2");

    AST_SOF_STAMP: assert property (s_sof_to_store
        |=> st_timestamp == $past(ts_ff, 5))
        else $error("stored timestamp not the sof capture");

endmodule
`default_nettype wire

/* File: testbench/can_node_model.sv */
// far-side nodes and receive rule feeding accepted frames to the block
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
    input  wire logic                    clk_sys,
    output var  logic                    frm_sof,
    output var  logic                    frm_valid,
    output var  logic                    frm_is_own,
    output var  can_rx_opts_pkg::dlc_t   frm_dlc,
    output var  logic [511:0]            frm_data,
    output var  logic                    rule_loopback_target,
    output var  can_rx_opts_pkg::dlc_t   rule_dlc,
    output var  can_rx_opts_pkg::dest_t  frm_dest
);
    import can_rx_opts_pkg::*;
    logic [511:0] pat;

    initial
    begin
        for (int i = 0; i < 64; i++)
            pat[8*i+:8] = 8'(i + 1);
        frm_sof = 1'b0;
        frm_valid = 1'b0;
        frm_is_own = 1'b0;
        frm_dlc = 4'h0;
        frm_data = ~pat;
        rule_loopback_target = 1'b0;
        rule_dlc = 4'h0;
        frm_dest = 2'h3;
    end

    // start of frame, then the accepted frame qualified for one cycle
    task automatic send(input logic own, input logic lb, input dlc_t d,
                        input dlc_t rd, input dest_t dst);
        @(posedge clk_sys) frm_sof <= 1'b1;
        @(posedge clk_sys) frm_sof <= 1'b0;
        repeat (3) @(posedge clk_sys);
        frm_valid <= 1'b1;
        frm_is_own <= own;
        rule_loopback_target <= lb;
        frm_dlc <= d;
        rule_dlc <= rd;
        frm_dest <= dst;
        frm_data <= pat;
        @(posedge clk_sys);
        // fields no longer qualified: show garbage, not the last value
        frm_valid <= 1'b0;
        frm_is_own <= ~own;
        rule_loopback_target <= ~lb;
        frm_dlc <= ~d;
        rule_dlc <= ~rd;
        frm_dest <= ~dst;
        frm_data <= ~pat;
    endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench of the global receive option block
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_opts_defs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin $display("unexpected %s exp %0h got %0h", n, e, g); err_count++; end end
module testbench;
    import can_rx_opts_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] chan_bit_tick = 4'h0;
    logic [3:0] chan_stopped;
    logic frm_sof, frm_valid, frm_is_own, rule_loopback_target, st_valid;
    logic can_clock_source_select;
    dlc_t frm_dlc, rule_dlc, st_dlc;
    dest_t frm_dest, st_dest;
    stamp_t st_timestamp;
    logic [511:0] frm_data, st_data;
    int err_count = 0;
    int n_tests = 0;

    can_rx_global_filter_options u_can_rx_global_filter_options (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_bit_tick(chan_bit_tick),
        .chan_stopped(chan_stopped), .frm_sof(frm_sof),
        .frm_valid(frm_valid), .frm_is_own(frm_is_own), .frm_dlc(frm_dlc),
        .frm_data(frm_data), .rule_loopback_target(rule_loopback_target),
        .rule_dlc(rule_dlc), .frm_dest(frm_dest), .st_valid(st_valid),
        .st_dlc(st_dlc), .st_data(st_data), .st_timestamp(st_timestamp),
        .st_dest(st_dest),
        .can_clock_source_select(can_clock_source_select));

    can_node_model u_can_node_model (
        .clk_sys(clk_sys), .frm_sof(frm_sof), .frm_valid(frm_valid),
        .frm_is_own(frm_is_own), .frm_dlc(frm_dlc), .frm_data(frm_data),
        .rule_loopback_target(rule_loopback_target), .rule_dlc(rule_dlc),
        .frm_dest(frm_dest));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // channel 1 ticks every cycle, channel 0 every other cycle
    always @(posedge clk_sys)
        chan_bit_tick <= {2'b00, 1'b1, ~chan_bit_tick[0]};

    function automatic logic [511:0] keep(input int n);
        keep = '0;
        for (int i = 0; i < n; i++)
            keep[8*i+:8] = 8'(i + 1);
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys) penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // config rewrites happen with every channel held stopped
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        logic [3:0] s;
        s = chan_stopped;
        if (a == `OFS_GLOBAL_CONFIG)
            chan_stopped <= 4'hF;
        apb(1'b1, a, d, q, e);
        if (a == `OFS_GLOBAL_CONFIG)
            chan_stopped <= s;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        `CHK("prdata", x, q)
    endtask

    task automatic frame(input logic own, input logic lb, input dlc_t d,
                         input dlc_t r, input dest_t dst, input logic st,
                         input dlc_t ed, input int n);
        u_can_node_model.send(own, lb, d, r, dst);
        #1;
        `CHK("st_valid", st, st_valid)
        if (st)
        begin
            `CHK("st_dlc", ed, st_dlc)
            `CHK("st_data", keep(n), st_data)
            `CHK("st_dest", dst, st_dest)
        end
    endtask

    task automatic ts(input stamp_t diff);
        stamp_t a;
        frame(1'b0, 1'b0, 4'h1, 4'h0, `DEST_RXBUF, 1'b1, 4'h1, 1);
        a = st_timestamp;
        frame(1'b0, 1'b0, 4'h1, 4'h0, `DEST_RXBUF, 1'b1, 4'h1, 1);
        `CHK("stamp", diff, stamp_t'(st_timestamp - a))
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        final_report();
    end

    initial
    begin : main
        logic [31:0] q;
        logic e;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        chan_stopped = 4'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`OFS_GLOBAL_CONFIG, `CFG_RESET);
        rd(`OFS_PAYLOAD_SIZE, `PLS_RESET);
        rd(`OFS_ERROR_FLAGS, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        `CHK("pslverr", 1'b1, e)
        wr(`OFS_GLOBAL_CONFIG, 32'hFFFF_FFFF);
        rd(`OFS_GLOBAL_CONFIG, `CFG_WMASK);
        `CHK("clk_sel", 1'b1, can_clock_source_select)
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0000);
        #1;
        `CHK("clk_sel", 1'b0, can_clock_source_select)
        wr(`OFS_PAYLOAD_SIZE, 32'h0000_0777);
        rd(`OFS_PAYLOAD_SIZE, 32'h0000_0777);
        done("registers");
        frame(1'b0, 1'b0, 4'h2, 4'h5, `DEST_RXBUF, 1'b1, 4'h2, 2);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0002);
        frame(1'b0, 1'b0, 4'hC, 4'h3, `DEST_RXBUF, 1'b1, 4'hC, 24);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0001);
        frame(1'b0, 1'b0, 4'h4, 4'h5, `DEST_RXBUF, 1'b0, 4'h0, 0);
        rd(`OFS_ERROR_FLAGS, 32'h0000_0001);
        wr(`OFS_ERROR_FLAGS, 32'h0000_0001);
        rd(`OFS_ERROR_FLAGS, 32'h0000_0000);
        frame(1'b0, 1'b0, 4'h5, 4'h5, `DEST_RXBUF, 1'b1, 4'h5, 5);
        frame(1'b0, 1'b0, 4'hF, 4'h5, `DEST_RXBUF, 1'b1, 4'hF, 64);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0003);
        frame(1'b0, 1'b0, 4'hC, 4'h3, `DEST_RXBUF, 1'b1, 4'h3, 3);
        frame(1'b0, 1'b0, 4'hC, 4'h0, `DEST_RXBUF, 1'b1, 4'hC, 24);
        done("dlc");
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0000);
        frame(1'b1, 1'b1, 4'h1, 4'h0, `DEST_RXBUF, 1'b0, 4'h0, 0);
        frame(1'b0, 1'b1, 4'h1, 4'h0, `DEST_RXBUF, 1'b0, 4'h0, 0);
        frame(1'b1, 1'b0, 4'h1, 4'h0, `DEST_RXBUF, 1'b0, 4'h0, 0);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0004);
        frame(1'b1, 1'b1, 4'h2, 4'h0, `DEST_RXBUF, 1'b1, 4'h2, 2);
        frame(1'b0, 1'b1, 4'h1, 4'h0, `DEST_RXBUF, 1'b0, 4'h0, 0);
        frame(1'b0, 1'b0, 4'h3, 4'h0, `DEST_RXBUF, 1'b1, 4'h3, 3);
        done("mirror");
        wr(`OFS_PAYLOAD_SIZE, 32'h0000_0707);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0000);
        frame(1'b0, 1'b0, 4'h9, 4'h0, `DEST_RXFIFO, 1'b0, 4'h0, 0);
        rd(`OFS_ERROR_FLAGS, 32'h0000_0002);
        wr(`OFS_ERROR_FLAGS, 32'h0000_0002);
        frame(1'b0, 1'b0, 4'h8, 4'h0, `DEST_RXFIFO, 1'b1, 4'h8, 8);
        rd(`OFS_ERROR_FLAGS, 32'h0000_0000);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0010);
        frame(1'b0, 1'b0, 4'h9, 4'h0, `DEST_RXFIFO, 1'b1, 4'h9, 8);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0013);
        frame(1'b0, 1'b0, 4'hC, 4'hA, `DEST_RXFIFO, 1'b1, 4'hA, 8);
        frame(1'b0, 1'b0, 4'hF, 4'h0, `DEST_TXRXFIFO, 1'b1, 4'hF, 64);
        rd(`OFS_ERROR_FLAGS, 32'h0000_0002);
        done("overflow");
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0000);
        ts(16'h0003);
        @(posedge clk_sys) chan_stopped <= 4'hF;
        ts(16'h0003);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_0120);
        ts(16'h0000);
        apb(1'b0, `OFS_TIMESTAMP, 32'h0000_0000, q, e);
        `CHK("ts_reg", {16'h0000, st_timestamp}, q)
        @(posedge clk_sys) chan_stopped <= 4'h0;
        ts(16'h0006);
        wr(`OFS_GLOBAL_CONFIG, 32'h0000_1120);
        ts(16'h0003);
        done("timestamp");
        final_report();
    end
endmodule
`default_nettype wire
